// >>> hw/qfb_flag_bus.sv
`timescale 1ns/1ps
`default_nettype none
module qfb_flag_bus
  import qfb_pkg::*;
#(
  parameter int QUEUES = 8,
  parameter int CNT_W  = 8
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  // straps, sampled while reset is low
  input  wire logic               flag_bus_mode_select,
  input  wire logic               packet_mode_select,
  input  wire logic               ring_leader_select,
  input  wire logic [POS_W-1:0]   chain_position_code,
  // write port
  input  wire logic               write_en,
  input  wire logic               write_queue_select,
  input  wire logic [WADDR_W-1:0] write_queue_address,
  input  wire logic               packet_begin_marker_in,
  input  wire logic               packet_finish_marker_in,
  input  wire logic               full_side_bus_strobe,
  // read port
  input  wire logic               read_en,
  input  wire logic               read_queue_select,
  input  wire logic [RADDR_W-1:0] read_queue_address,
  input  wire logic               packet_begin_marker_out,
  input  wire logic               empty_side_bus_strobe,
  // queue status from the core; almost flags active low, not-empty active high
  input  wire logic [BUS_W-1:0]   queue_almost_full_n,
  input  wire logic [BUS_W-1:0]   queue_almost_empty_n,
  input  wire logic [BUS_W-1:0]   queue_not_empty,
  // token ring
  input  wire logic               full_side_token_in,
  output logic                    full_side_token_out,
  output logic                    full_side_ring_pulse,
  // almost-full bus
  output logic [BUS_W-1:0]        almost_full_bus_o,
  output logic                    almost_full_bus_oe,
  // read flag bus, almost empty or packet ready
  output logic [BUS_W-1:0]        almost_empty_bus_o,
  output logic                    almost_empty_bus_oe,
  // discrete active flags, active low
  output logic                    almost_full_flag_n,
  output logic                    almost_empty_flag_n,
  output logic                    packet_ready_flag_n,
  output logic                    output_valid_flag_n
);
  // ------------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------------
  if (QUEUES < 1 || QUEUES > BUS_W)
    $error("QUEUES must lie between 1 and the bus width");
  if (CNT_W < 1)
    $error("CNT_W must be at least 1");
  if (QUEUES > (1 << QSEL_W))
    $error("QUEUES exceeds the queue field of the addresses");
  if (POS_W > WADDR_W - WPOS_LSB || POS_W > RADDR_W - RPOS_LSB)
    $error("device field does not fit the address buses");

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  qfb_straps_s       straps_q;
  logic              wr_dev_q;
  logic [QSEL_W-1:0] wr_queue_q;
  logic              rd_dev_q;
  logic [QSEL_W-1:0] rd_queue_q;
  logic              af_owner_q;
  logic              ae_owner_q;
  logic [QUEUES-1:0] ready_q;
  logic [BUS_W-1:0]  ready_n;
  logic              ring_take;
  logic              ring_token;
  logic              ring_pulse;
  logic              wr_go;
  logic              rd_go;
  logic              polled;
  logic [POS_W-1:0]  wr_pos;
  logic [POS_W-1:0]  rd_pos;
  logic [QSEL_W-1:0] wr_qsel;
  logic [QSEL_W-1:0] rd_qsel;
  logic [BUS_W-1:0]  rd_status;
  logic [BUS_W-1:0]  af_status;
  logic [BUS_W-1:0]  ae_status;
  logic [BUS_W-1:0]  ov_status;
  logic [QSEL_W-1:0] wr_flag_sel;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // one queue's bit of a status vector; queues not built read idle high
  function automatic logic queue_bit(input logic [BUS_W-1:0]  v,
                                     input logic [QSEL_W-1:0] q);
    if (int'(q) >= QUEUES)
      return 1'b1;
    return v[q];
  endfunction : queue_bit

  // status vector with bits of queues not built held idle high
  function automatic logic [BUS_W-1:0] mask_unused(
    input logic [BUS_W-1:0] v
  );
    logic [BUS_W-1:0] m;
    m = v;
    for (int i = QUEUES; i < BUS_W; i++)
      m[i] = 1'b1;
    return m;
  endfunction : mask_unused

  // ------------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------------
  // straps held while master reset is low, frozen after release
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      straps_q.mode        <= qfb_mode_e'(flag_bus_mode_select);
      straps_q.packet_mode <= packet_mode_select;
      straps_q.ring_leader <= ring_leader_select;
      straps_q.chain_pos   <= chain_position_code;
    end
  end

  // ------------------------------------------------------------------
  // address fields
  // ------------------------------------------------------------------
  // device and queue fields of the two address buses
  assign wr_pos  = write_queue_address[WPOS_LSB +: POS_W];
  assign rd_pos  = read_queue_address[RPOS_LSB +: POS_W];
  assign wr_qsel = write_queue_address[QIDX_LSB +: QSEL_W];
  assign rd_qsel = read_queue_address[QIDX_LSB +: QSEL_W];
  assign polled  = straps_q.mode == QFB_POLLED;

  // ------------------------------------------------------------------
  // status conditioning
  // ------------------------------------------------------------------
  // queues not built show idle on buses and discrete flags
  assign af_status = mask_unused(queue_almost_full_n);
  assign ae_status = mask_unused(queue_almost_empty_n);
  assign ov_status = mask_unused(~queue_not_empty);
  // discrete almost-full flag follows a new write queue at once
  assign wr_flag_sel = write_queue_select ? wr_qsel : wr_queue_q;

  // ------------------------------------------------------------------
  // active queue selection
  // ------------------------------------------------------------------
  // write port: this device named by the queue selection
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      wr_dev_q <= 1'b0;
    else if (write_queue_select)
      wr_dev_q <= qfb_pos_match(wr_pos, straps_q.chain_pos);
  end

  // write port: active queue within the device
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      wr_queue_q <= '0;
    else if (write_queue_select)
      wr_queue_q <= wr_qsel;
  end

  // read port: this device named by the queue selection
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      rd_dev_q <= 1'b0;
    else if (read_queue_select)
      rd_dev_q <= qfb_pos_match(rd_pos, straps_q.chain_pos);
  end

  // read port: active queue within the device
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      rd_queue_q <= '0;
    else if (read_queue_select)
      rd_queue_q <= rd_qsel;
  end

  // accesses that land in this device
  assign wr_go = write_en && wr_dev_q;
  assign rd_go = read_en && rd_dev_q;

  // ------------------------------------------------------------------
  // packet tracking
  // ------------------------------------------------------------------
  // count complete packets per queue, first pipeline stage
  qfb_pr_track #(
    .QUEUES (QUEUES),
    .CNT_W  (CNT_W)
  ) u_track (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .wr_en     (wr_go),
    .wr_q      (wr_queue_q),
    .begin_in  (packet_begin_marker_in),
    .finish_in (packet_finish_marker_in),
    .rd_en     (rd_go),
    .rd_q      (rd_queue_q),
    .begin_out (packet_begin_marker_out),
    .ready_q   (ready_q)
  );

  // active low ready per queue, unused bits read as not ready
  always_comb begin
    ready_n = RST_BUS;
    for (int i = 0; i < QUEUES; i++)
      ready_n[i] = ~ready_q[i];
  end

  // ------------------------------------------------------------------
  // polled ring
  // ------------------------------------------------------------------
  // token circulation, leader seeds first edge after reset
  qfb_ring u_ring (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .enable    (polled),
    .leader    (straps_q.ring_leader),
    .token_in  (full_side_token_in),
    .take_next (ring_take),
    .token_q   (ring_token),
    .pulse_q   (ring_pulse)
  );

  // token and sync outputs, low whenever not owning
  assign full_side_token_out  = ring_token;
  assign full_side_ring_pulse = ring_pulse;

  // ------------------------------------------------------------------
  // almost-full bus ownership
  // ------------------------------------------------------------------
  // addressed mode: strobe with matching device field selects
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      af_owner_q <= 1'b0;
    else if (!polled && full_side_bus_strobe)
      af_owner_q <= qfb_pos_match(wr_pos, straps_q.chain_pos);
  end

  // addressed: enable follows the owner one cycle after the select edge; polled: same edge as the token
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      almost_full_bus_oe <= 1'b0;
    else if (polled)
      almost_full_bus_oe <= ring_take;
    else
      almost_full_bus_oe <= af_owner_q;
  end

  // ------------------------------------------------------------------
  // almost-full bus data
  // ------------------------------------------------------------------
  // bus bits sample status each cycle, may trail a fresh access
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      almost_full_bus_o <= RST_BUS;
    else
      almost_full_bus_o <= af_status;
  end

  // discrete flag picks the active write queue directly
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      almost_full_flag_n <= RST_FLAG;
    else
      almost_full_flag_n <= queue_bit(af_status, wr_flag_sel);
  end

  // ------------------------------------------------------------------
  // read flag bus ownership
  // ------------------------------------------------------------------
  // addressed mode only; polled leaves the read bus undriven
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      ae_owner_q <= 1'b0;
    else if (polled)
      ae_owner_q <= 1'b0;
    else if (empty_side_bus_strobe)
      ae_owner_q <= qfb_pos_match(rd_pos, straps_q.chain_pos);
  end

  // enable follows the owner one cycle after the select edge
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      almost_empty_bus_oe <= 1'b0;
    else
      almost_empty_bus_oe <= ae_owner_q;
  end

  // ------------------------------------------------------------------
  // read flag bus data
  // ------------------------------------------------------------------
  // strap selects packet ready or almost empty content
  assign rd_status = straps_q.packet_mode ? ready_n
                                          : ae_status;

  // second ready stage: bus bit moves two edges after the cause;
  // no extra cycle is added on a read queue switch
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      almost_empty_bus_o <= RST_BUS;
    else
      almost_empty_bus_o <= rd_status;
  end

  // ------------------------------------------------------------------
  // discrete read flags
  // ------------------------------------------------------------------
  // active read queue almost-empty flag
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      almost_empty_flag_n <= RST_FLAG;
    else
      almost_empty_flag_n <= queue_bit(ae_status, rd_queue_q);
  end

  // active read queue packet-ready flag
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      packet_ready_flag_n <= RST_FLAG;
    else
      packet_ready_flag_n <= queue_bit(ready_n, rd_queue_q);
  end

  // active read queue output-valid flag
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      output_valid_flag_n <= RST_FLAG;
    else
      output_valid_flag_n <= queue_bit(ov_status, rd_queue_q);
  end
endmodule : qfb_flag_bus
`default_nettype wire

// >>> hw/qfb_pr_track.sv
`timescale 1ns/1ps
`default_nettype none
module qfb_pr_track
  import qfb_pkg::*;
#(
  parameter int QUEUES = 8,
  parameter int CNT_W  = 8
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // write side
  input  wire logic              wr_en,
  input  wire logic [QSEL_W-1:0] wr_q,
  input  wire logic              begin_in,
  input  wire logic              finish_in,
  // read side
  input  wire logic              rd_en,
  input  wire logic [QSEL_W-1:0] rd_q,
  input  wire logic              begin_out,
  // per-queue complete packet present
  output logic [QUEUES-1:0]      ready_q
);
  logic [CNT_W-1:0]  cnt_q [QUEUES];
  logic [QUEUES-1:0] open_q;
  logic [QUEUES-1:0] inc;
  logic [QUEUES-1:0] dec;

  // per-queue count up on a closing end marker, down on a begin read
  always_comb begin
    for (int i = 0; i < QUEUES; i++) begin
      inc[i] = wr_en && wr_q == QSEL_W'(i) && finish_in && open_q[i];
      dec[i] = rd_en && rd_q == QSEL_W'(i) && begin_out && cnt_q[i] != '0;
    end
  end

  // packet counts and open-packet marks
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < QUEUES; i++) begin
      if (!reset_n) begin
        cnt_q[i]  <= '0;
        open_q[i] <= 1'b0;
      end else begin
        if (inc[i] && !dec[i] && cnt_q[i] != '1)
          cnt_q[i] <= cnt_q[i] + CNT_W'(1);
        else if (dec[i] && !inc[i])
          cnt_q[i] <= cnt_q[i] - CNT_W'(1);
        if (wr_en && wr_q == QSEL_W'(i)) begin
          if (finish_in)
            open_q[i] <= 1'b0;
          else if (begin_in)
            open_q[i] <= 1'b1;
        end
      end
    end
  end

  // first stage of the ready pipeline
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < QUEUES; i++)
      ready_q[i] <= reset_n && cnt_q[i] != '0;
  end
endmodule : qfb_pr_track
`default_nettype wire

// >>> hw/qfb_ring.sv
`timescale 1ns/1ps
`default_nettype none
module qfb_ring
  import qfb_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // configuration
  input  wire logic enable,
  input  wire logic leader,
  // ring
  input  wire logic token_in,
  output logic      take_next,
  output logic      token_q,
  output logic      pulse_q
);
  qfb_ring_e state_q;

  // start-up sequence after reset release
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      state_q <= QFB_RING_HOLD;
    else begin
      case (state_q)
        QFB_RING_HOLD:  state_q <= QFB_RING_START;
        QFB_RING_START: state_q <= QFB_RING_RUN;
        QFB_RING_RUN:   state_q <= QFB_RING_RUN;
        default:        state_q <= QFB_RING_HOLD;
      endcase
    end
  end

  // leader seeds the token, then it follows the ring
  always_comb begin
    case (state_q)
      QFB_RING_HOLD: take_next = enable && leader;
      QFB_RING_START,
      QFB_RING_RUN:  take_next = enable && token_in;
      default:       take_next = 1'b0;
    endcase
  end

  // token held and leader sync pulse
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      token_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      token_q <= take_next;
      pulse_q <= take_next && leader;
    end
  end
endmodule : qfb_ring
`default_nettype wire

// >>> pkg/qfb_pkg.sv
`default_nettype none
package qfb_pkg;
  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int BUS_W   = 8;
  localparam int QSEL_W  = 3;
  localparam int POS_W   = 3;
  localparam int WADDR_W = 6;
  localparam int RADDR_W = 7;
  // ------------------------------------------------------------------
  // address fields
  // ------------------------------------------------------------------
  localparam int WPOS_LSB = 3;
  localparam int RPOS_LSB = 4;
  localparam int QIDX_LSB = 0;
  // ------------------------------------------------------------------
  // timing counts, core clock cycles
  // ------------------------------------------------------------------
  localparam int PR_SET_LAT = 2;
  localparam int PR_CLR_LAT = 2;
  localparam int SEL_LAT    = 1;
  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [BUS_W-1:0] RST_BUS  = 8'hff;
  localparam logic             RST_FLAG = 1'h1;
  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic {
    QFB_ADDRESSED = 1'b0,
    QFB_POLLED    = 1'b1
  } qfb_mode_e;

  typedef enum logic [1:0] {
    QFB_RING_HOLD  = 2'b00,
    QFB_RING_START = 2'b01,
    QFB_RING_RUN   = 2'b10
  } qfb_ring_e;

  typedef struct packed {
    qfb_mode_e         mode;
    logic              packet_mode;
    logic              ring_leader;
    logic [POS_W-1:0]  chain_pos;
  } qfb_straps_s;

  // true when an address's device field names this device
  function automatic logic qfb_pos_match(input logic [POS_W-1:0] a,
                                         input logic [POS_W-1:0] p);
    return a == p;
  endfunction : qfb_pos_match
endpackage : qfb_pkg
`default_nettype wire

// >>> tb/qfb_flag_bus_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module qfb_flag_bus_assertions
  import qfb_pkg::*;
(
  // clock, reset and straps
  input wire logic               core_clk,
  input wire logic               reset_n,
  input wire logic               flag_bus_mode_select,
  input wire logic               ring_leader_select,
  input wire logic [POS_W-1:0]   chain_position_code,
  // bus selects and status
  input wire logic [WADDR_W-1:0] write_queue_address,
  input wire logic               full_side_bus_strobe,
  input wire logic [RADDR_W-1:0] read_queue_address,
  input wire logic               empty_side_bus_strobe,
  input wire logic [BUS_W-1:0]   queue_almost_full_n,
  // ring and bus outputs
  input wire logic               full_side_token_in,
  input wire logic               full_side_token_out,
  input wire logic               full_side_ring_pulse,
  input wire logic [BUS_W-1:0]   almost_full_bus_o,
  input wire logic               almost_full_bus_oe,
  input wire logic               almost_empty_bus_oe
);
  logic             poll_q;
  logic             lead_q;
  logic [POS_W-1:0] pos_q;
  logic             wsel;
  logic             rsel;
  logic             wme;
  logic             rme;

  // straps held while reset is low
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      poll_q <= flag_bus_mode_select;
      lead_q <= ring_leader_select;
      pos_q  <= chain_position_code;
    end
  end

  // addressed bus selects and device match
  assign wsel = !poll_q && full_side_bus_strobe;
  assign rsel = !poll_q && empty_side_bus_strobe;
  assign wme  = write_queue_address[WADDR_W-1:WPOS_LSB] == pos_q;
  assign rme  = read_queue_address[RADDR_W-1:RPOS_LSB] == pos_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // owning cycle on the ring
  sequence s_turn;
    full_side_token_out && almost_full_bus_oe;
  endsequence

  chk_af_take_bus:
    assert property (wsel && wme |-> ##2 almost_full_bus_oe)
    else $error("almost-full bus not taken after match");
  chk_af_drop_bus:
    assert property (wsel && !wme |-> ##2 !almost_full_bus_oe)
    else $error("almost-full bus driven when not selected");
  chk_ae_take_bus:
    assert property (rsel && rme |-> ##2 almost_empty_bus_oe)
    else $error("read bus not taken after match");
  chk_ae_drop_bus:
    assert property (rsel && !rme |-> ##2 !almost_empty_bus_oe)
    else $error("read bus driven when not selected");
  chk_af_data_follow:
    assert property ($past(reset_n) |->
      almost_full_bus_o == $past(queue_almost_full_n))
    else $error("almost-full bus content stale");
  chk_token_pass_on:
    assert property (poll_q && full_side_token_in |=> s_turn)
    else $error("token not taken on next cycle");
  chk_leader_first_turn:
    assert property ($rose(reset_n) && poll_q && lead_q |=>
      s_turn ##0 full_side_ring_pulse)
    else $error("leader missed first turn");
  chk_sync_pulse_once:
    assert property (full_side_ring_pulse |->
      lead_q && full_side_token_out ##1 !full_side_ring_pulse)
    else $error("sync pulse wrong");
  chk_idle_bus_quiet:
    assert property (poll_q && !full_side_token_out |->
      !almost_full_bus_oe)
    else $error("bus driven without token");
endmodule : qfb_flag_bus_assertions

bind qfb_flag_bus qfb_flag_bus_assertions u_qfb_flag_bus_assertions (
  .core_clk, .reset_n, .flag_bus_mode_select, .ring_leader_select,
  .chain_position_code, .write_queue_address, .full_side_bus_strobe,
  .read_queue_address, .empty_side_bus_strobe, .queue_almost_full_n,
  .full_side_token_in, .full_side_token_out, .full_side_ring_pulse,
  .almost_full_bus_o, .almost_full_bus_oe, .almost_empty_bus_oe
);
`default_nettype wire

// >>> tb/qfb_ring_peer.sv
`timescale 1ns/1ps
`default_nettype none
module qfb_ring_peer #(
  parameter int PEERS = 3
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // ring
  input  wire logic token_from_dev,
  output logic      token_to_dev,
  output logic      peer_bus_oe
);
  logic [PEERS-1:0] own_q;

  // each peer owns the cycle after its token input
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      own_q <= '0;
    end else begin
      own_q <= {own_q[PEERS-2:0], token_from_dev};
    end
  end

  // last peer hands back; peers drive only while owning
  assign token_to_dev = own_q[PEERS-1];
  assign peer_bus_oe  = |own_q;
endmodule : qfb_ring_peer
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import qfb_pkg::*;
;
  logic               core_clk, reset_n, fm, pkt, lead;
  logic [POS_W-1:0]   pos;
  logic               w_en, w_sel, w_stb, b_in, f_in;
  logic [WADDR_W-1:0] w_addr;
  logic               r_en, r_sel, r_stb, b_out;
  logic [RADDR_W-1:0] r_addr;
  logic [BUS_W-1:0]   af_n, ae_n, ne, af_bus, ae_bus;
  logic               tok_in, tok_out, pulse, af_oe, ae_oe, peer_oe;
  logic               af_fl_n, ae_fl_n, pr_fl_n, ov_fl_n;
  int                 error_cnt = 0;
  int                 num_checks = 0;
  int                 cyc_cnt = 0;

  // device under test and ring neighbours
  qfb_flag_bus u_qfb_flag_bus (
    .core_clk(core_clk), .reset_n(reset_n),
    .flag_bus_mode_select(fm), .packet_mode_select(pkt),
    .ring_leader_select(lead), .chain_position_code(pos),
    .write_en(w_en), .write_queue_select(w_sel),
    .write_queue_address(w_addr), .packet_begin_marker_in(b_in),
    .packet_finish_marker_in(f_in), .full_side_bus_strobe(w_stb),
    .read_en(r_en), .read_queue_select(r_sel),
    .read_queue_address(r_addr), .packet_begin_marker_out(b_out),
    .empty_side_bus_strobe(r_stb), .queue_almost_full_n(af_n),
    .queue_almost_empty_n(ae_n), .queue_not_empty(ne),
    .full_side_token_in(tok_in), .full_side_token_out(tok_out),
    .full_side_ring_pulse(pulse), .almost_full_bus_o(af_bus),
    .almost_full_bus_oe(af_oe), .almost_empty_bus_o(ae_bus),
    .almost_empty_bus_oe(ae_oe), .almost_full_flag_n(af_fl_n),
    .almost_empty_flag_n(ae_fl_n), .packet_ready_flag_n(pr_fl_n),
    .output_valid_flag_n(ov_fl_n)
  );
  qfb_ring_peer u_qfb_ring_peer (
    .core_clk(core_clk), .reset_n(reset_n), .token_from_dev(tok_out),
    .token_to_dev(tok_in), .peer_bus_oe(peer_oe)
  );

  // clock and hang guard
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 1000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end

  // compare and report
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  // one write-port cycle: {en,sel,strobe}, address, {begin,finish}
  task automatic wcyc(input logic [2:0] c, input logic [5:0] a,
                      input logic [1:0] m);
    {w_en, w_sel, w_stb, w_addr, b_in, f_in} = {c, a, m};
    @(negedge core_clk);
  endtask : wcyc

  // one read-port cycle: {en,sel,strobe}, address, begin marker
  task automatic rcyc(input logic [2:0] c, input logic [6:0] a,
                      input logic m);
    {r_en, r_sel, r_stb, r_addr, b_out} = {c, a, m};
    @(negedge core_clk);
  endtask : rcyc

  task automatic reset_dut(input logic [2:0] s);
    {fm, pkt, lead} = s;
    reset_n = 1'h0;
    repeat (6) @(negedge core_clk);
    reset_n = 1'h1;
  endtask : reset_dut

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    pos = 3'h3;
    af_n = 8'ha5;
    ae_n = 8'h3c;
    ne = 8'h02;
    {w_en, w_sel, w_stb, w_addr, b_in, f_in} = '0;
    {r_en, r_sel, r_stb, r_addr, b_out} = '0;
    reset_dut(3'h0);
    check(8'({af_oe, ae_oe}), 8'h00);
    check(8'({af_fl_n, ae_fl_n, pr_fl_n, ov_fl_n}), 8'h0f);
    wcyc(3'h2, {pos, 3'h1}, 2'h0);
    wcyc(3'h1, {pos, 3'h0}, 2'h0);
    wcyc(3'h1, {3'h5, 3'h0}, 2'h0);
    check(8'(af_oe), 8'h01);
    wcyc(3'h0, 6'h00, 2'h0);
    check(8'(af_oe), 8'h00);
    check(af_bus, 8'ha5);
    check(8'(af_fl_n), 8'h00);
    rcyc(3'h2, {pos, 4'h1}, 1'h0);
    rcyc(3'h1, {pos, 4'h0}, 1'h0);
    rcyc(3'h1, {3'h6, 4'h0}, 1'h0);
    check(8'(ae_oe), 8'h01);
    rcyc(3'h0, 7'h00, 1'h0);
    check(8'(ae_oe), 8'h00);
    check(ae_bus, 8'h3c);
    check(8'({ae_fl_n, ov_fl_n}), 8'h00);
    $display("test addressed done");
    reset_dut(3'h2);
    rcyc(3'h2, {pos, 4'h2}, 1'h0);
    rcyc(3'h0, 7'h00, 1'h0);
    wcyc(3'h2, {pos, 3'h4}, 2'h0);
    wcyc(3'h4, 6'h00, 2'h1);
    wcyc(3'h2, {pos, 3'h2}, 2'h0);
    wcyc(3'h4, 6'h00, 2'h2);
    wcyc(3'h4, 6'h00, 2'h1);
    wcyc(3'h4, 6'h00, 2'h2);
    check(ae_bus, 8'hff);
    wcyc(3'h4, 6'h00, 2'h1);
    check(ae_bus, 8'hfb);
    check(8'(pr_fl_n), 8'h00);
    wcyc(3'h0, 6'h00, 2'h0);
    rcyc(3'h4, 7'h00, 1'h1);
    rcyc(3'h4, 7'h00, 1'h1);
    rcyc(3'h0, 7'h00, 1'h0);
    check(ae_bus, 8'hfb);
    @(negedge core_clk);
    check(ae_bus, 8'hff);
    check(8'(pr_fl_n), 8'h01);
    $display("test packet done");
    reset_dut(3'h5);
    @(negedge core_clk);
    check(8'({tok_out, pulse, af_oe}), 8'h07);
    for (int k = 1; k <= 8; k++) begin
      @(negedge core_clk);
      check(8'(tok_out), 8'((k % 4) == 0));
      check(8'(pulse), 8'((k % 4) == 0));
      check(8'({af_oe & peer_oe, ae_oe}), 8'h00);
    end
    $display("test polled done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
